// ===== vsc_setpoint_bank.sv
// Output setpoint, input threshold and overvoltage reaction bank
`include "vsc_defines.svh"
`timescale 1ns/100ps
module vsc_setpoint_bank #(
    parameter logic [15:0] SW_RATE_WORD = 16'h0000,
    parameter int DLY_UNIT_CYC = `VSC_DLY_UNIT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command port
    input wire logic [7:0] cmd_code,
    input wire logic cmd_wr,
    input wire logic [15:0] cmd_wdata,
    input wire logic cmd_rd,
    output logic [15:0] cmd_rdata_r,
    output logic cmd_rvalid_r,
    output logic cmd_nack_r,
    // Controller inputs
    input wire logic [7:0] vout_mode,
    input wire logic [15:0] vout_nominal,
    input wire logic [1:0] margin_sel,
    input wire logic op_on,
    input wire logic clear_faults,
    input wire logic ov_status_clr,
    // Pins
    input wire logic [15:0] strap_vout,
    input wire logic ctrl_pin,
    // Measurements
    input wire logic [15:0] vout_meas,
    input wire logic [15:0] vin_meas,
    input wire logic [15:0] iout_raw,
    // Results
    output logic [15:0] vout_ref_r,
    output logic [15:0] iout_report_r,
    output logic conv_run_r,
    output logic output_en_r,
    output logic ov_fault_r,
    output logic ov_flag_r,
    output logic [2:0] retries_r,
    output vsc_pkg::vsc_fmt_t vout_fmt_r,
    output logic [4:0] vout_exp_r,
    // Loop settings
    output logic [15:0] droop_word,
    output logic [15:0] loop_gain_word,
    output logic [15:0] mon_scale_word,
    output logic [15:0] duty_word
);
    import vsc_pkg::*;

    localparam int TICK_CYC = `VSC_RAMP_TICK_CYC;
    localparam int CAP_DLY_LO = 1;
    localparam int CAP_DLY_HI = 8;

    // Command to word index; bit 4 flags a mapped word
    function automatic logic [4:0] cmd_index(input logic [7:0] c);
        logic [4:0] r;
        r = 5'h00;
        if (c == `VSC_CMD_CEILING) r = {1'b1, `VSC_IDX_CEILING};
        else if (c == `VSC_CMD_MARGIN_UP) r = {1'b1, `VSC_IDX_MARGIN_UP};
        else if (c == `VSC_CMD_MARGIN_DN) r = {1'b1, `VSC_IDX_MARGIN_DN};
        else if (c == `VSC_CMD_SLEW) r = {1'b1, `VSC_IDX_SLEW};
        else if (c == `VSC_CMD_DROOP) r = {1'b1, `VSC_IDX_DROOP};
        else if (c == `VSC_CMD_LOOP_GAIN) r = {1'b1, `VSC_IDX_LOOP_GAIN};
        else if (c == `VSC_CMD_MON_SCALE) r = {1'b1, `VSC_IDX_MON_SCALE};
        else if (c == `VSC_CMD_DUTY) r = {1'b1, `VSC_IDX_DUTY};
        else if (c == `VSC_CMD_VIN_ON) r = {1'b1, `VSC_IDX_VIN_ON};
        else if (c == `VSC_CMD_VIN_OFF) r = {1'b1, `VSC_IDX_VIN_OFF};
        else if (c == `VSC_CMD_IOUT_OFFS) r = {1'b1, `VSC_IDX_IOUT_OFFS};
        else if (c == `VSC_CMD_OV_LIMIT) r = {1'b1, `VSC_IDX_OV_LIMIT};
        else if (c == `VSC_CMD_OV_REACT) r = {1'b1, `VSC_IDX_OV_REACT};
        return r;
    endfunction : cmd_index

    // Unsigned compare in the current output-voltage format
    function automatic logic vout_gt(input logic [15:0] a,
                                     input logic [15:0] b,
                                     input vsc_fmt_t f);
        if (f == VSC_FMT_CODE_ID) return a[7:0] > b[7:0];
        return a > b;
    endfunction : vout_gt

    // Pin synchronisers
    logic ctrl_m_r, ctrl_s_r, en_cmd_d_r;
    logic [15:0] strap_m_r, strap_s_r, strap_r;
    logic [3:0] cap_cnt_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_m_r <= 1'b0;
            ctrl_s_r <= 1'b0;
            strap_m_r <= 16'h0000;
            strap_s_r <= 16'h0000;
        end else begin
            ctrl_m_r <= ctrl_pin;
            ctrl_s_r <= ctrl_m_r;
            strap_m_r <= strap_vout;
            strap_s_r <= strap_m_r;
        end
    end

    // Strap followed for 8 cycles after reset release, then held
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cap_cnt_r <= 4'h0;
            strap_r <= 16'h0000;
        end else if (cap_cnt_r != 4'(CAP_DLY_HI)) begin
            cap_cnt_r <= cap_cnt_r + 4'h1;
            strap_r <= strap_s_r;
        end
    end

    // Register memory
    logic [4:0] idx_w;
    logic [15:0] wdata_w;
    logic mem_wr_w;
    logic [15:0] mem_rdata;
    logic [255:0] words;
    logic [19:0] ceil_lim_w;

    assign idx_w = cmd_index(cmd_code);
    assign ceil_lim_w = 20'(({8'h00, strap_r} * 24'(`VSC_CEIL_PCT))
                            / 24'(`VSC_PCT_BASE));
    assign mem_wr_w = cmd_wr && idx_w[4];

    always_comb begin
        wdata_w = cmd_wdata;
        if (idx_w[3:0] == `VSC_IDX_CEILING &&
            {4'h0, cmd_wdata} > ceil_lim_w) begin
            wdata_w = ceil_lim_w[15:0];
        end else if (idx_w[3:0] == `VSC_IDX_OV_REACT) begin
            wdata_w = cmd_wdata & `VSC_REACT_MASK;
        end
    end

    vsc_regmem #(
        .DW(16),
        .AW(4),
        .DEPTH(16)
    ) u_mem (
        .clk(clk),
        .rst(rst),
        .wr_en(mem_wr_w),
        .wr_addr(idx_w[3:0]),
        .wr_data(wdata_w),
        .rd_en(cmd_rd),
        .rd_addr(idx_w[3:0]),
        .rd_data_r(mem_rdata),
        .words(words)
    );

    function automatic logic [15:0] word_at(input logic [255:0] w,
                                            input logic [3:0] i);
        return w[{i, 4'h0} +: 16];
    endfunction : word_at

    logic [15:0] ceil_w, mup_w, mdn_w, slew_w, von_w, voff_w;
    logic [15:0] ioffs_w, ovl_w, react_w;
    assign ceil_w = word_at(words, `VSC_IDX_CEILING);
    assign mup_w = word_at(words, `VSC_IDX_MARGIN_UP);
    assign mdn_w = word_at(words, `VSC_IDX_MARGIN_DN);
    assign slew_w = word_at(words, `VSC_IDX_SLEW);
    assign von_w = word_at(words, `VSC_IDX_VIN_ON);
    assign voff_w = word_at(words, `VSC_IDX_VIN_OFF);
    assign ioffs_w = word_at(words, `VSC_IDX_IOUT_OFFS);
    assign ovl_w = word_at(words, `VSC_IDX_OV_LIMIT);
    assign react_w = word_at(words, `VSC_IDX_OV_REACT);
    assign droop_word = word_at(words, `VSC_IDX_DROOP);
    assign loop_gain_word = word_at(words, `VSC_IDX_LOOP_GAIN);
    assign mon_scale_word = word_at(words, `VSC_IDX_MON_SCALE);
    assign duty_word = word_at(words, `VSC_IDX_DUTY);

    // Read answer two cycles after the request
    logic rd_p_r, rd_ro_r, rd_bad_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_p_r <= 1'b0;
            rd_ro_r <= 1'b0;
            rd_bad_r <= 1'b0;
            cmd_rdata_r <= 16'h0000;
            cmd_rvalid_r <= 1'b0;
            cmd_nack_r <= 1'b0;
        end else begin
            rd_p_r <= cmd_rd;
            rd_ro_r <= cmd_code == `VSC_CMD_SW_RATE;
            rd_bad_r <= !idx_w[4] && cmd_code != `VSC_CMD_SW_RATE;
            cmd_rvalid_r <= rd_p_r;
            if (rd_p_r) begin
                if (rd_ro_r) cmd_rdata_r <= SW_RATE_WORD;
                else if (rd_bad_r) cmd_rdata_r <= 16'h0000;
                else cmd_rdata_r <= mem_rdata;
            end
            // Writes to the read-only rate vanish without a nack
            cmd_nack_r <= (cmd_rd || cmd_wr) && !idx_w[4] &&
                          cmd_code != `VSC_CMD_SW_RATE;
        end
    end

    // Output format from the mode byte
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vout_fmt_r <= VSC_FMT_LINEAR;
            vout_exp_r <= 5'h00;
        end else begin
            vout_exp_r <= vout_mode[4:0];
            if (vout_mode[7:5] == `VSC_MODE_CODE_ID)
                vout_fmt_r <= VSC_FMT_CODE_ID;
            else if (vout_mode[7:5] == `VSC_MODE_DIRECT)
                vout_fmt_r <= VSC_FMT_DIRECT;
            else
                vout_fmt_r <= VSC_FMT_LINEAR;
        end
    end

    // Target selection and ramp
    logic [15:0] tgt_w, step_w;
    logic [7:0] tick_cnt_r;
    logic ramp_tick;
    always_comb begin
        tgt_w = vout_nominal;
        if (margin_sel == `VSC_MARGIN_HIGH) tgt_w = mup_w;
        else if (margin_sel == `VSC_MARGIN_LOW) tgt_w = mdn_w;
        if (ceil_w != 16'h0000 && vout_gt(tgt_w, ceil_w, vout_fmt_r))
            tgt_w = ceil_w;
    end
    assign step_w = {5'h00, slew_w[`VSC_SLEW_MANT_HI:0]};
    assign ramp_tick = tick_cnt_r == 8'(TICK_CYC - 1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) tick_cnt_r <= 8'h00;
        else if (ramp_tick) tick_cnt_r <= 8'h00;
        else tick_cnt_r <= tick_cnt_r + 8'h01;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vout_ref_r <= 16'h0000;
        end else if (ramp_tick) begin
            if (step_w == 16'h0000) vout_ref_r <= tgt_w;
            else if (tgt_w > vout_ref_r)
                vout_ref_r <= (tgt_w - vout_ref_r > step_w) ?
                              vout_ref_r + step_w : tgt_w;
            else
                vout_ref_r <= (vout_ref_r - tgt_w > step_w) ?
                              vout_ref_r - step_w : tgt_w;
        end
    end

    // Input thresholds and current report
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_run_r <= 1'b0;
            iout_report_r <= 16'h0000;
        end else begin
            iout_report_r <= iout_raw + ioffs_w;
            if (conv_run_r && vin_meas <= voff_w) conv_run_r <= 1'b0;
            else if (!conv_run_r && vin_meas >= von_w)
                conv_run_r <= 1'b1;
        end
    end

    // Overvoltage reaction
    logic fault_w, clr_w, en_cmd_w, retry_ok_w, load_w, inc_w;
    logic [1:0] code_w;
    logic [2:0] rty_w;
    logic [23:0] cnt_r, dly_w;
    vsc_state_t st_r, st_nxt;

    assign fault_w = vout_gt(vout_meas, ovl_w, vout_fmt_r);
    assign code_w = react_w[`VSC_REACT_CODE_HI:`VSC_REACT_CODE_LO];
    assign rty_w = react_w[`VSC_REACT_RTY_HI:`VSC_REACT_RTY_LO];
    assign dly_w = 24'(react_w[`VSC_REACT_DLY_HI:`VSC_REACT_DLY_LO]
                       * DLY_UNIT_CYC);
    assign en_cmd_w = op_on && ctrl_s_r;
    assign clr_w = ov_status_clr || clear_faults ||
                   (en_cmd_w && !en_cmd_d_r);
    assign retry_ok_w = rty_w == `VSC_RTY_FOREVER ||
                        (rty_w != `VSC_RTY_NONE && retries_r < rty_w);

    always_comb begin
        st_nxt = st_r;
        load_w = 1'b0;
        inc_w = 1'b0;
        case (st_r)
            VSC_ST_OK: begin
                if (fault_w && code_w == `VSC_CODE_DELAYED) begin
                    st_nxt = VSC_ST_DELAY;
                    load_w = 1'b1;
                end else if (fault_w && code_w == `VSC_CODE_DISABLE) begin
                    st_nxt = retry_ok_w ? VSC_ST_OFFWAIT : VSC_ST_LATCH;
                    load_w = 1'b1;
                end else if (fault_w && code_w == `VSC_CODE_HOLD) begin
                    st_nxt = VSC_ST_HOLD;
                end
            end
            VSC_ST_DELAY: begin
                if (cnt_r == 24'h0 && fault_w) begin
                    st_nxt = retry_ok_w ? VSC_ST_OFFWAIT : VSC_ST_LATCH;
                    load_w = 1'b1;
                end else if (cnt_r == 24'h0) begin
                    st_nxt = VSC_ST_OK;
                end
            end
            VSC_ST_OFFWAIT: begin
                if (cnt_r == 24'h0) begin
                    st_nxt = VSC_ST_RESTART;
                    load_w = 1'b1;
                    inc_w = 1'b1;
                end
            end
            VSC_ST_RESTART: begin
                if (fault_w) begin
                    st_nxt = retry_ok_w ? VSC_ST_OFFWAIT : VSC_ST_LATCH;
                    load_w = 1'b1;
                end else if (cnt_r == 24'h0) begin
                    st_nxt = VSC_ST_OK;
                end
            end
            VSC_ST_HOLD: begin
                if (!fault_w) st_nxt = VSC_ST_OK;
            end
            default: begin
                st_nxt = st_r;
            end
        endcase
        if (clr_w) st_nxt = VSC_ST_OK;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= VSC_ST_OK;
            cnt_r <= 24'h0;
            en_cmd_d_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            en_cmd_d_r <= en_cmd_w;
            if (load_w) cnt_r <= dly_w;
            else if (cnt_r != 24'h0) cnt_r <= cnt_r - 24'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            retries_r <= 3'h0;
        end else if (clr_w || (st_r == VSC_ST_RESTART &&
                               st_nxt == VSC_ST_OK)) begin
            retries_r <= 3'h0;
        end else if (inc_w && retries_r != 3'h7) begin
            retries_r <= retries_r + 3'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            output_en_r <= 1'b1;
            ov_fault_r <= 1'b0;
            ov_flag_r <= 1'b0;
        end else begin
            output_en_r <= st_nxt == VSC_ST_OK || st_nxt == VSC_ST_DELAY ||
                           st_nxt == VSC_ST_RESTART;
            ov_fault_r <= fault_w;
            // Set wins over a clear in the same cycle
            if (fault_w) ov_flag_r <= 1'b1;
            else if (clr_w) ov_flag_r <= 1'b0;
        end
    end

    // Checks
    sequence s_ok_fault(logic [1:0] c);
        st_r == VSC_ST_OK && fault_w && !clr_w && code_w == c;
    endsequence

    a_ceil_clamp: assert property (@(posedge clk) disable iff (rst)
        cmd_wr && cmd_code == `VSC_CMD_CEILING && cap_cnt_r == 4'(CAP_DLY_HI)
        |=> {4'h0, ceil_w} <= ceil_lim_w)
        else $error("ceiling above strap limit");
    a_tgt_high: assert property (@(posedge clk) disable iff (rst)
        margin_sel == `VSC_MARGIN_HIGH &&
        (ceil_w == 16'h0000 || !vout_gt(mup_w, ceil_w, vout_fmt_r))
        |-> tgt_w == mup_w)
        else $error("margin high target wrong");
    a_tgt_low: assert property (@(posedge clk) disable iff (rst)
        margin_sel == `VSC_MARGIN_LOW &&
        (ceil_w == 16'h0000 || !vout_gt(mdn_w, ceil_w, vout_fmt_r))
        |-> tgt_w == mdn_w)
        else $error("margin low target wrong");
    a_ramp_tick: assert property (@(posedge clk) disable iff (rst)
        $changed(vout_ref_r) |-> $past(ramp_tick))
        else $error("reference moved off tick");
    a_rate_ro: assert property (@(posedge clk) disable iff (rst)
        cmd_rd && cmd_code == `VSC_CMD_SW_RATE
        |-> ##2 cmd_rvalid_r && cmd_rdata_r == SW_RATE_WORD)
        else $error("switching rate read wrong");
    a_vin_on: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && !conv_run_r && vin_meas >= von_w |=> conv_run_r)
        else $error("conversion did not start");
    a_vin_off: assert property (@(posedge clk) disable iff (rst)
        conv_run_r && vin_meas <= voff_w |=> !conv_run_r)
        else $error("conversion did not stop");
    a_iout_offs: assert property (@(posedge clk) disable iff (rst)
        !$past(rst)
        |=> iout_report_r == 16'($past(iout_raw) + $past(ioffs_w)))
        else $error("current offset wrong");
    a_ov_ignore: assert property (@(posedge clk) disable iff (rst)
        s_ok_fault(`VSC_CODE_IGNORE) |=> st_r == VSC_ST_OK && output_en_r)
        else $error("ignore code interrupted output");
    a_ov_disable: assert property (@(posedge clk) disable iff (rst)
        s_ok_fault(`VSC_CODE_DISABLE) |=> !output_en_r)
        else $error("output not disabled");
    a_hold_resume: assert property (@(posedge clk) disable iff (rst)
        st_r == VSC_ST_HOLD && !fault_w |=> st_r == VSC_ST_OK && output_en_r)
        else $error("hold did not resume");
    a_clear_all: assert property (@(posedge clk) disable iff (rst)
        clear_faults |=> st_r == VSC_ST_OK && retries_r == 3'h0)
        else $error("clear faults ignored");
    a_flag_wins: assert property (@(posedge clk) disable iff (rst)
        fault_w && ov_status_clr |=> ov_flag_r)
        else $error("fault flag lost on clear");
    a_no_retry: assert property (@(posedge clk) disable iff (rst)
        s_ok_fault(`VSC_CODE_DISABLE) ##0 rty_w == `VSC_RTY_NONE
        |=> st_r == VSC_ST_LATCH)
        else $error("retry taken with count zero");
endmodule : vsc_setpoint_bank

// ===== vsc_defines.svh
// Command codes, field positions and timing constants of the setpoint bank
`ifndef VSC_DEFINES_SVH
`define VSC_DEFINES_SVH

`define VSC_CMD_CEILING 8'h24
`define VSC_CMD_MARGIN_UP 8'h25
`define VSC_CMD_MARGIN_DN 8'h26
`define VSC_CMD_SLEW 8'h27
`define VSC_CMD_DROOP 8'h28
`define VSC_CMD_LOOP_GAIN 8'h29
`define VSC_CMD_MON_SCALE 8'h2a
`define VSC_CMD_DUTY 8'h32
`define VSC_CMD_SW_RATE 8'h33
`define VSC_CMD_VIN_ON 8'h35
`define VSC_CMD_VIN_OFF 8'h36
`define VSC_CMD_IOUT_OFFS 8'h39
`define VSC_CMD_OV_LIMIT 8'h40
`define VSC_CMD_OV_REACT 8'h41

`define VSC_IDX_CEILING 4'h0
`define VSC_IDX_MARGIN_UP 4'h1
`define VSC_IDX_MARGIN_DN 4'h2
`define VSC_IDX_SLEW 4'h3
`define VSC_IDX_DROOP 4'h4
`define VSC_IDX_LOOP_GAIN 4'h5
`define VSC_IDX_MON_SCALE 4'h6
`define VSC_IDX_DUTY 4'h7
`define VSC_IDX_VIN_ON 4'h8
`define VSC_IDX_VIN_OFF 4'h9
`define VSC_IDX_IOUT_OFFS 4'ha
`define VSC_IDX_OV_LIMIT 4'hb
`define VSC_IDX_OV_REACT 4'hc

`define VSC_REACT_CODE_HI 7
`define VSC_REACT_CODE_LO 6
`define VSC_REACT_RTY_HI 5
`define VSC_REACT_RTY_LO 3
`define VSC_REACT_DLY_HI 2
`define VSC_REACT_DLY_LO 0
`define VSC_REACT_MASK 16'h00ff
`define VSC_SLEW_MANT_HI 10

`define VSC_CODE_IGNORE 2'h0
`define VSC_CODE_DELAYED 2'h1
`define VSC_CODE_DISABLE 2'h2
`define VSC_CODE_HOLD 2'h3
`define VSC_RTY_NONE 3'h0
`define VSC_RTY_FOREVER 3'h7

`define VSC_MODE_LINEAR 3'h0
`define VSC_MODE_CODE_ID 3'h1
`define VSC_MODE_DIRECT 3'h2

`define VSC_MARGIN_NONE 2'h0
`define VSC_MARGIN_LOW 2'h1
`define VSC_MARGIN_HIGH 2'h2

`define VSC_CEIL_PCT 110
`define VSC_PCT_BASE 100

`define VSC_CLK_PERIOD_NS 10
`define VSC_RAMP_TICK_NS 1000
`define VSC_RAMP_TICK_CYC (`VSC_RAMP_TICK_NS / `VSC_CLK_PERIOD_NS)
`define VSC_DLY_UNIT_US 1000
`define VSC_DLY_UNIT_CYC (`VSC_DLY_UNIT_US * 1000 / `VSC_CLK_PERIOD_NS)

`endif

// ===== vsc_pkg.sv
// Types shared by the setpoint bank files
package vsc_pkg;
    typedef enum logic [2:0] {
        VSC_FMT_LINEAR = 3'h1,
        VSC_FMT_CODE_ID = 3'h2,
        VSC_FMT_DIRECT = 3'h4
    } vsc_fmt_t;

    typedef enum logic [5:0] {
        VSC_ST_OK = 6'h01,
        VSC_ST_DELAY = 6'h02,
        VSC_ST_OFFWAIT = 6'h04,
        VSC_ST_RESTART = 6'h08,
        VSC_ST_LATCH = 6'h10,
        VSC_ST_HOLD = 6'h20
    } vsc_state_t;
endpackage : vsc_pkg

// ===== vsc_regmem.sv
// Small word memory holding the configuration words
`timescale 1ns/100ps
module vsc_regmem #(
    parameter int DW = 16,
    parameter int AW = 4,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    // Read port
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data_r,
    // All words for the control logic
    output logic [DEPTH*DW-1:0] words
);
    logic [DW-1:0] mem_r [DEPTH];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_r <= '0;
        end else if (rd_en) begin
            rd_data_r <= mem_r[rd_addr];
        end
    end

    for (genvar g = 0; g < DEPTH; g++) begin : g_words
        assign words[g*DW +: DW] = mem_r[g];
    end
endmodule : vsc_regmem

// ===== vsc_host.sv
// Host model driving the command port of the bank
`timescale 1ns/100ps
module vsc_host (
    // Clock
    input wire logic clk,
    // Command port
    output logic [7:0] cmd_code,
    output logic cmd_wr,
    output logic [15:0] cmd_wdata,
    output logic cmd_rd,
    input wire logic [15:0] cmd_rdata_r,
    input wire logic cmd_rvalid_r
);
    initial begin
        cmd_code = 8'h00;
        cmd_wr = 1'b0;
        cmd_wdata = 16'h0000;
        cmd_rd = 1'b0;
    end
    // Released lines show inverted values
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        cmd_code <= c;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge clk);
        cmd_wr <= 1'b0;
        cmd_code <= ~c;
        cmd_wdata <= ~d;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] c, output logic [15:0] d,
                      output logic ok);
        cmd_code <= c;
        cmd_rd <= 1'b1;
        @(posedge clk);
        cmd_rd <= 1'b0;
        cmd_code <= ~c;
        repeat (2) @(posedge clk);
        ok = cmd_rvalid_r;
        d = cmd_rdata_r;
    endtask : rd
endmodule : vsc_host

// ===== vsc_setpoint_bank_tb.sv
// Self-checking bench for the setpoint and overvoltage bank
`timescale 1ns/100ps
module vsc_setpoint_bank_tb;
    import vsc_pkg::*;
    logic clk, rst, wr, rd, rv, clr, sclr, en, run, flag, nk, ovf, on, pin;
    logic [7:0] code, mode;
    logic [15:0] wd, rdat, vref, iout, vm, vi, ir, dw, d, lg, ms, du;
    logic [2:0] rt;
    logic [4:0] ex;
    logic [1:0] msel;
    vsc_fmt_t fmt;
    int n_mismatch = 0;
    int n_tests = 0;
    int k;
    localparam logic [7:0] TBL [11] = '{8'h25, 8'h26, 8'h27, 8'h28,
        8'h29, 8'h2a, 8'h32, 8'h35, 8'h36, 8'h39, 8'h40};
    vsc_host host (.clk(clk), .cmd_code(code), .cmd_wr(wr),
        .cmd_wdata(wd), .cmd_rd(rd), .cmd_rdata_r(rdat),
        .cmd_rvalid_r(rv));
    vsc_setpoint_bank #(.SW_RATE_WORD(16'h1234), .DLY_UNIT_CYC(4)) uut (
        .clk(clk), .rst(rst), .cmd_code(code), .cmd_wr(wr),
        .cmd_wdata(wd), .cmd_rd(rd), .cmd_rdata_r(rdat),
        .cmd_rvalid_r(rv), .cmd_nack_r(nk), .vout_mode(mode),
        .vout_nominal(16'h0000), .margin_sel(msel), .op_on(on),
        .clear_faults(clr), .ov_status_clr(sclr), .strap_vout(16'h1000),
        .ctrl_pin(pin), .vout_meas(vm), .vin_meas(vi), .iout_raw(ir),
        .vout_ref_r(vref), .iout_report_r(iout), .conv_run_r(run),
        .output_en_r(en), .ov_fault_r(ovf), .ov_flag_r(flag), .retries_r(rt),
        .vout_fmt_r(fmt), .vout_exp_r(ex), .droop_word(dw),
        .loop_gain_word(lg), .mon_scale_word(ms), .duty_word(du));
    task automatic stop_test();
        if (n_mismatch == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic ck(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : ck
    task automatic rc(input logic [7:0] c, input logic [15:0] e);
        logic ok;
        host.rd(c, d, ok);
        ck(16'(ok), 16'h0001);
        ck(d, e);
    endtask : rc
    task automatic clear();
        clr <= 1'b1;
        cyc(1);
        clr <= 1'b0;
        cyc(3);
    endtask : clear
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #300000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        rst = 1'b1;
        mode = 8'h00;
        msel = 2'h0;
        clr = 1'b0;
        sclr = 1'b0;
        on = 1'b1;
        pin = 1'b1;
        vm = 16'h0000;
        vi = 16'h0000;
        ir = 16'h0010;
        cyc(2);
        rst <= 1'b0;
        cyc(10);
        host.wr(8'h24, 16'hffff);
        rc(8'h24, 16'h1199);
        host.wr(8'h24, 16'h1000);
        foreach (TBL[i]) host.wr(TBL[i], {4'h0, TBL[i], 4'h5});
        foreach (TBL[i]) rc(TBL[i], {4'h0, TBL[i], 4'h5});
        ck(dw, 16'h0285);
        ck(lg, 16'h0295);
        ck(ms, 16'h02a5);
        ck(du, 16'h0325);
        host.wr(8'h33, 16'h5555);
        ck(16'(nk), 16'h0000);
        rc(8'h33, 16'h1234);
        host.wr(8'h30, 16'h7777);
        ck(16'(nk), 16'h0001);
        rc(8'h30, 16'h0000);
        ck(iout, 16'h03a5);
        msel <= 2'h2;
        cyc(250);
        ck(vref, 16'h0255);
        msel <= 2'h1;
        cyc(250);
        ck(vref, 16'h0265);
        host.wr(8'h35, 16'h0064);
        host.wr(8'h36, 16'h0050);
        for (int i = 0; i < 4; i++) begin
            vi <= (i == 1) ? 16'h0064 : (i == 3) ? 16'h0050 : 16'h005a;
            cyc(3);
            ck(16'(run), 16'((i == 1) || (i == 2)));
        end
        for (int m = 0; m < 3; m++) begin
            mode <= {3'(m), 5'(m + 5)};
            cyc(3);
            ck(16'(fmt), 16'(1 << m));
            ck(16'(ex), 16'(m + 5));
        end
        mode <= 8'h00;
        host.wr(8'h41, 16'habcd);
        rc(8'h41, 16'h00cd);
        host.wr(8'h41, 16'h0000);
        vm <= 16'h0500;
        cyc(5);
        ck(16'({en, flag}), 16'h0003);
        ck(16'(ovf), 16'h0001);
        sclr <= 1'b1;
        cyc(1);
        sclr <= 1'b0;
        cyc(1);
        ck(16'(flag), 16'h0001);
        vm <= 16'h0000;
        clear();
        ck(16'(flag), 16'h0000);
        host.wr(8'h41, 16'h00c0);
        vm <= 16'h0500;
        cyc(5);
        ck(16'(en), 16'h0000);
        vm <= 16'h0000;
        cyc(5);
        ck(16'(en), 16'h0001);
        host.wr(8'h41, 16'h0080);
        vm <= 16'h0500;
        cyc(5);
        ck(16'(en), 16'h0000);
        vm <= 16'h0000;
        cyc(20);
        ck(16'(en), 16'h0000);
        sclr <= 1'b1;
        cyc(1);
        sclr <= 1'b0;
        cyc(3);
        ck(16'(en), 16'h0001);
        host.wr(8'h41, 16'h0041);
        vm <= 16'h0500;
        cyc(3);
        ck(16'(en), 16'h0001);
        cyc(20);
        ck(16'(en), 16'h0000);
        vm <= 16'h0000;
        clear();
        ck(16'(en), 16'h0001);
        host.wr(8'h41, 16'h0089);
        vm <= 16'h0500;
        cyc(4);
        ck(16'(en), 16'h0000);
        k = 0;
        while (en !== 1'b1 && k < 30) begin
            cyc(1);
            k++;
        end
        ck(16'(k < 30), 16'h0001);
        cyc(30);
        ck(16'(en), 16'h0000);
        ck(16'(rt), 16'h0001);
        vm <= 16'h0000;
        clear();
        ck(16'(en), 16'h0001);
        ck(16'(rt), 16'h0000);
        host.wr(8'h41, 16'h0080);
        for (int p = 0; p < 2; p++) begin
            vm <= 16'h0500;
            cyc(3);
            vm <= 16'h0000;
            if (p == 0) on <= 1'b0;
            else pin <= 1'b0;
            cyc(5);
            ck(16'(en), 16'h0000);
            on <= 1'b1;
            pin <= 1'b1;
            cyc(5);
            ck(16'(en), 16'h0001);
        end
        stop_test();
    end
endmodule : vsc_setpoint_bank_tb
